// >>> src/fte_map.svh
// register map, field positions, reset values and mode codes of the fsk transmit encoder
// What this block does
// [RULE_01] drive bit clock except oversampled mode
// [RULE_02] bit rate is clock over dividers times 32
// [RULE_03] deviation word scales output, halving halves it
// [RULE_04] 2fsk steps plus or minus deviation per bit
// [RULE_05] host sets deviation quarter rate for msk
// [RULE_06] three bit field selects the eight modes
// [RULE_07] 3fsk zero is carrier, one is offset
// [RULE_08] precoder xors input with output two back
// [RULE_09] encoder is precoder minus precoder two back
// [RULE_10] 3fsk emits one symbol per input bit
// [RULE_11] 4fsk pairs bits into four level symbols
// [RULE_12] gray mapped pairs at one or three deviations
// [RULE_13] first pulse after divider write carries msb
// [RULE_14] oversampled mode samples line at 32x rate
// [RULE_15] asynchronous host data only in oversampled mode
// [RULE_16] gaussian shaping only with 2fsk
// [RULE_17] raised cosine rolloff 0.5, select bit gives 0.7
// [RULE_18] shaping filters are linear phase
// [RULE_19] sample data on rising bit clock edge
// [RULE_20] unfiltered bit reaches output one bit later (oversampled mode skips the pending stage, no bit delay)
// [RULE_21] encoder delays clear at transmission start
`ifndef FTE_MAP_SVH
`define FTE_MAP_SVH

//------------------------------------------------------------
// register offsets and bus answers
//------------------------------------------------------------
`define FTE_ADDR_CTRL   4'h0
`define FTE_ADDR_DIV    4'h4
`define FTE_ADDR_DEV    4'h8
`define FTE_ADDR_STAT   4'hc
`define FTE_RESP_OKAY   2'h0
`define FTE_RESP_SLVERR 2'h2

//------------------------------------------------------------
// field positions
//------------------------------------------------------------
`define FTE_MOD_LSB     0
`define FTE_MOD_MSB     2
`define FTE_ROLL_BIT    3
`define FTE_HALVE_BIT   4
`define FTE_EN_BIT      8
`define FTE_DEMOD_LSB   0
`define FTE_DEMOD_MSB   3
`define FTE_CDR_LSB     4
`define FTE_CDR_MSB     11
`define FTE_DEV_LSB     0
`define FTE_DEV_MSB     8
`define FTE_ST_RUN_BIT  0
`define FTE_ST_CLK_BIT  1
`define FTE_ST_LVL_LSB  2
`define FTE_ST_LVL_MSB  4
`define FTE_ST_PAIR_BIT 5

//------------------------------------------------------------
// reset values
//------------------------------------------------------------
`define FTE_DEMOD_RST   4'h1
`define FTE_CDR_RST     8'h01
`define FTE_DEV_RST     9'h001

//------------------------------------------------------------
// modulation codes
//------------------------------------------------------------
`define FTE_MOD_2FSK    3'h0
`define FTE_MOD_GFSK    3'h1
`define FTE_MOD_3FSK    3'h2
`define FTE_MOD_4FSK    3'h3
`define FTE_MOD_OVS     3'h4
`define FTE_MOD_RC2     3'h5
`define FTE_MOD_RC3     3'h6
`define FTE_MOD_RC4     3'h7

//------------------------------------------------------------
// timing counts: 32 phases per bit, ramp lengths as log2 ticks
//------------------------------------------------------------
`define FTE_PHASE_LAST  5'h1f
`define FTE_RAMP_NONE   3'h0
`define FTE_RAMP_GAUSS  3'h4
`define FTE_RAMP_RC05   3'h5
`define FTE_RAMP_RC07   3'h4
`define FTE_LVL_SHIFT   5

`endif

// >>> src/fte_pkg.sv
// types shared by the fsk transmit encoder files
package fte_pkg;

  typedef logic signed [2:0] fte_level_t;

  typedef enum logic {ST_IDLE, ST_RUN} fte_state_t;

  typedef struct packed {
    logic [2:0] mode;
    logic       rolloff;
    logic       halve;
    logic       enable;
    logic [3:0] demod;
    logic [7:0] cdr;
    logic [8:0] dev;
  } fte_cfg_t;

endpackage

// >>> src/fte_shaper.sv
// linear-phase ramp shaper between successive symbol levels
`include "fte_map.svh"
module fte_shaper (
  input  logic               clk,
  input  logic               ce,
  input  logic               sys_rst,
  input  logic               tick,
  input  logic               load,
  input  fte_pkg::fte_level_t level,
  input  logic [2:0]         ramp_log2,
  output logic signed [7:0]  shaped
);

  logic signed [7:0] target_q;
  logic signed [7:0] step;
  logic signed [7:0] new_target;
  logic signed [8:0] diff;
  logic signed [7:0] next_step;
  logic [5:0]        left;

  // a symmetric ramp is its own time mirror, so group delay is flat
  always_comb begin
    new_target = 8'(level) <<< `FTE_LVL_SHIFT;
    diff       = 9'(new_target) - 9'(target_q);
    next_step  = 8'(diff >>> ramp_log2);
  end

  // ramp starts from the last target, so a ramp cut short by a mode change cannot drift
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      target_q <= '0;
      step     <= '0;
      shaped   <= '0;
      left     <= '0;
    end else if (ce) begin
      if (load) begin
        target_q <= new_target;
        if (ramp_log2 == `FTE_RAMP_NONE) begin
          shaped <= new_target;
          left   <= '0;
        end else begin // [RULE_18]
          step   <= next_step;
          shaped <= target_q + next_step;
          left   <= 6'((7'h01 << ramp_log2) - 7'h01);
        end
      end else if (tick && left != 6'h00) begin
        shaped <= shaped + step;
        left   <= left - 6'h01;
      end
    end
  end

endmodule

// >>> src/fte_tx_encoder.sv
// fsk transmit modulation encoder with bit clock generator and axi4-lite registers
`include "fte_map.svh"
module fte_tx_encoder #(
  parameter int ADDR_W = 4
) (
  input  logic              clk,
  input  logic              ce,
  input  logic              sys_rst,
  input  logic [ADDR_W-1:0] s_axi_awaddr,
  input  logic              s_axi_awvalid,
  output logic              s_axi_awready,
  input  logic [31:0]       s_axi_wdata,
  input  logic [3:0]        s_axi_wstrb,
  input  logic              s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  logic              s_axi_bready,
  input  logic [ADDR_W-1:0] s_axi_araddr,
  input  logic              s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  logic              s_axi_rready,
  input  logic              host_bit_line,
  output logic              host_bit_clock,
  output logic              host_bit_clock_oe,
  output logic signed [16:0] freq_dev_cmd,
  output logic              sym_strobe
);

  //------------------------------------------------------------
  // declarations
  //------------------------------------------------------------
  fte_pkg::fte_cfg_t   cfg;
  fte_pkg::fte_state_t state;
  fte_pkg::fte_state_t next_state;
  fte_pkg::fte_level_t pend_lvl;
  fte_pkg::fte_level_t new_lvl;
  fte_pkg::fte_level_t shp_lvl;
  logic [ADDR_W-1:0]   aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                aw_hold;
  logic                w_hold;
  logic                wr_go;
  logic [31:0]         wr_mask;
  logic [31:0]         wr_val;
  logic                div_wr;
  logic [2:0]          sync;
  logic                line_q;
  logic [3:0]          demod_eff;
  logic [7:0]          cdr_eff;
  logic [11:0]         div_last;
  logic [11:0]         pre_cnt;
  logic [4:0]          phase;
  logic [4:0]          next_phase;
  logic                tick;
  logic                bit_edge;
  logic                run;
  logic                is3;
  logic                is4;
  logic                ovs;
  logic                p1;
  logic                p2;
  logic                pre_bit;
  logic                pair_ph;
  logic                msb;
  logic                load;
  logic [2:0]          ramp_log2;
  logic signed [7:0]   shaped;
  logic signed [17:0]  prod;
  logic signed [17:0]  scaled;

  //------------------------------------------------------------
  // register access helpers
  //------------------------------------------------------------
  function automatic logic map_hit(input logic [ADDR_W-1:0] a);
    return a == `FTE_ADDR_CTRL || a == `FTE_ADDR_DIV || a == `FTE_ADDR_DEV || a == `FTE_ADDR_STAT;
  endfunction

  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = '0;
    case (a)
      `FTE_ADDR_CTRL: begin
        w[`FTE_MOD_MSB:`FTE_MOD_LSB] = cfg.mode;
        w[`FTE_ROLL_BIT]             = cfg.rolloff;
        w[`FTE_HALVE_BIT]            = cfg.halve;
        w[`FTE_EN_BIT]               = cfg.enable;
      end
      `FTE_ADDR_DIV: begin
        w[`FTE_DEMOD_MSB:`FTE_DEMOD_LSB] = cfg.demod;
        w[`FTE_CDR_MSB:`FTE_CDR_LSB]     = cfg.cdr;
      end
      `FTE_ADDR_DEV: w[`FTE_DEV_MSB:`FTE_DEV_LSB] = cfg.dev;
      `FTE_ADDR_STAT: begin
        w[`FTE_ST_RUN_BIT]                 = run;
        w[`FTE_ST_CLK_BIT]                 = host_bit_clock;
        w[`FTE_ST_LVL_MSB:`FTE_ST_LVL_LSB] = pend_lvl;
        w[`FTE_ST_PAIR_BIT]                = pair_ph;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  // gray order of pairs 00 01 11 10 walks the levels -3 -1 +1 +3
  function automatic fte_pkg::fte_level_t gray4(input logic hi, input logic lo);
    case ({hi, lo})
      2'h0:    return -3'sd3;
      2'h1:    return -3'sd1;
      2'h3:    return 3'sd1;
      default: return 3'sd3;
    endcase
  endfunction

  //------------------------------------------------------------
  // axi4-lite write channel
  //------------------------------------------------------------
  assign wr_go   = aw_hold && w_hold && !s_axi_bvalid;
  assign div_wr  = ce && wr_go && aw_addr == `FTE_ADDR_DIV;
  assign wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // a process rather than an assign, so a change of any register read inside rd_word re-evaluates it
  always_comb begin
    wr_val = (rd_word(aw_addr) & ~wr_mask) | (w_data & wr_mask);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FTE_RESP_OKAY;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold       <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end else if (!aw_hold && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold       <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end else if (!w_hold && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= map_hit(aw_addr) ? `FTE_RESP_OKAY : `FTE_RESP_SLVERR;
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //------------------------------------------------------------
  // axi4-lite read channel
  //------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `FTE_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word(s_axi_araddr);
        s_axi_rresp   <= map_hit(s_axi_araddr) ? `FTE_RESP_OKAY : `FTE_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  //------------------------------------------------------------
  // configuration registers
  //------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg       <= '0;
      cfg.demod <= `FTE_DEMOD_RST;
      cfg.cdr   <= `FTE_CDR_RST;
      cfg.dev   <= `FTE_DEV_RST;
    end else if (ce && wr_go) begin
      case (aw_addr)
        `FTE_ADDR_CTRL: begin
          cfg.mode    <= wr_val[`FTE_MOD_MSB:`FTE_MOD_LSB]; // [RULE_06]
          cfg.rolloff <= wr_val[`FTE_ROLL_BIT];
          cfg.halve   <= wr_val[`FTE_HALVE_BIT];
          cfg.enable  <= wr_val[`FTE_EN_BIT];
        end
        `FTE_ADDR_DIV: begin
          cfg.demod <= wr_val[`FTE_DEMOD_MSB:`FTE_DEMOD_LSB];
          cfg.cdr   <= wr_val[`FTE_CDR_MSB:`FTE_CDR_LSB];
        end
        `FTE_ADDR_DEV: cfg.dev <= wr_val[`FTE_DEV_MSB:`FTE_DEV_LSB];
        default: cfg <= cfg;
      endcase
    end
  end

  //------------------------------------------------------------
  // host line synchroniser
  //------------------------------------------------------------
  // the line is asynchronous in oversampled mode, so it is always treated as such
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync   <= '0;
      line_q <= 1'b0;
    end else if (ce) begin
      sync <= {sync[1:0], host_bit_line};
      if (sync[1] == sync[2]) begin
        line_q <= sync[2];
      end
    end
  end

  //------------------------------------------------------------
  // bit clock generation
  //------------------------------------------------------------
  // a zero divider would stop the clock, so it counts as one
  assign demod_eff  = (cfg.demod == 4'h0) ? 4'h1 : cfg.demod;
  assign cdr_eff    = (cfg.cdr == 8'h00) ? 8'h01 : cfg.cdr;
  assign div_last   = ({8'h00, demod_eff} * {4'h0, cdr_eff}) - 12'h001; // [RULE_02]
  assign tick       = ce && pre_cnt >= div_last;
  assign next_phase = phase + 5'h01;
  assign bit_edge   = tick && phase == `FTE_PHASE_LAST && !div_wr;
  assign is3        = cfg.mode == `FTE_MOD_3FSK || cfg.mode == `FTE_MOD_RC3;
  assign is4        = cfg.mode == `FTE_MOD_4FSK || cfg.mode == `FTE_MOD_RC4;
  assign ovs        = cfg.mode == `FTE_MOD_OVS;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt           <= '0;
      phase             <= '0;
      host_bit_clock    <= 1'b0;
      host_bit_clock_oe <= 1'b0;
    end else if (ce) begin
      host_bit_clock_oe <= !ovs; // [RULE_14]
      if (div_wr) begin // [RULE_13]
        pre_cnt        <= '0;
        phase          <= '0;
        host_bit_clock <= 1'b0;
      end else if (tick) begin
        pre_cnt        <= '0;
        phase          <= next_phase;
        // rises only at a sample edge, so the first pulse after a divider write carries the first bit
        host_bit_clock <= (next_phase == 5'h00 || (host_bit_clock && !next_phase[4])) && !ovs; // [RULE_01] [RULE_19]
      end else begin
        pre_cnt        <= pre_cnt + 12'h001;
        host_bit_clock <= host_bit_clock && !ovs; // [RULE_14]
      end
    end
  end

  //------------------------------------------------------------
  // transmit state
  //------------------------------------------------------------
  assign run = state == fte_pkg::ST_RUN;

  always_comb begin
    next_state = state;
    case (state)
      fte_pkg::ST_IDLE: if (cfg.enable) next_state = fte_pkg::ST_RUN;
      fte_pkg::ST_RUN:  if (!cfg.enable) next_state = fte_pkg::ST_IDLE;
      default:          next_state = fte_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= fte_pkg::ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  //------------------------------------------------------------
  // symbol mapping
  //------------------------------------------------------------
  assign pre_bit = line_q ^ p2; // [RULE_08]

  always_comb begin
    new_lvl = '0;
    load    = 1'b0;
    if (run && ovs && tick) begin // [RULE_14] [RULE_15]
      load    = 1'b1;
      new_lvl = line_q ? 3'sd1 : -3'sd1;
    end else if (run && bit_edge && !ovs) begin
      if (is3) begin // [RULE_07] [RULE_09] [RULE_10]
        load    = 1'b1;
        new_lvl = (pre_bit && !p2) ? 3'sd1 : ((!pre_bit && p2) ? -3'sd1 : 3'sd0);
      end else if (is4) begin // [RULE_11]
        load    = pair_ph;
        new_lvl = gray4(msb, line_q); // [RULE_12]
      end else begin // [RULE_04] [RULE_16]
        load    = 1'b1;
        new_lvl = line_q ? 3'sd1 : -3'sd1;
      end
    end
  end

  // delays stay cleared while idle, so every transmission starts from zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      p1       <= 1'b0;
      p2       <= 1'b0;
      pair_ph  <= 1'b0;
      msb      <= 1'b0;
      pend_lvl <= '0;
    end else if (ce) begin
      if (!run || div_wr) begin // [RULE_21] [RULE_13]
        p1       <= 1'b0;
        p2       <= 1'b0;
        pair_ph  <= 1'b0;
        pend_lvl <= '0;
      end else if (bit_edge && !ovs) begin
        if (is3) begin
          p1 <= pre_bit;
          p2 <= p1;
        end
        if (is4) begin
          pair_ph <= !pair_ph;
          msb     <= line_q;
        end
        if (load) begin
          pend_lvl <= new_lvl; // [RULE_20]
        end
      end
    end
  end

  //------------------------------------------------------------
  // shaping and deviation scaling
  //------------------------------------------------------------
  always_comb begin
    case (cfg.mode)
      `FTE_MOD_GFSK: ramp_log2 = `FTE_RAMP_GAUSS;
      `FTE_MOD_RC2, `FTE_MOD_RC3, `FTE_MOD_RC4: ramp_log2 = cfg.rolloff ? `FTE_RAMP_RC07 : `FTE_RAMP_RC05; // [RULE_17]
      default: ramp_log2 = `FTE_RAMP_NONE;
    endcase
  end

  // the oversampled path has no bit alignment to wait for, so it skips the pending stage
  assign shp_lvl = ovs ? new_lvl : pend_lvl;

  fte_shaper u_shaper (
    .clk       (clk),
    .ce        (ce),
    .sys_rst   (sys_rst),
    .tick      (tick),
    .load      (load),
    .level     (shp_lvl),
    .ramp_log2 (ramp_log2),
    .shaped    (shaped)
  );

  // output unit is one thirty-second of the deviation lsb
  assign prod   = 18'(shaped) * $signed({1'b0, cfg.dev});
  assign scaled = prod >>> cfg.halve;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      freq_dev_cmd <= '0;
      sym_strobe   <= 1'b0;
    end else if (ce) begin
      freq_dev_cmd <= scaled[16:0]; // [RULE_03]
      sym_strobe   <= load;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  logic [16:0] gap_cnt;
  logic        gap_armed;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_cnt   <= '0;
      gap_armed <= 1'b0;
    end else if (ce) begin
      gap_cnt   <= bit_edge ? 17'h00000 : gap_cnt + 17'h00001;
      gap_armed <= div_wr ? 1'b0 : (bit_edge ? 1'b1 : gap_armed);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_take3;
    bit_edge && run && is3;
  endsequence
  sequence s_take4;
    load && is4 && !ovs;
  endsequence

  property p_osmp_noclk;
    ce && ovs ##1 ovs |-> !host_bit_clock_oe && !host_bit_clock;
  endproperty
  a_osmp_noclk: assert property (p_osmp_noclk) else $error("bit clock driven in oversampled mode"); // [RULE_14]

  property p_clk_rise;
    $rose(host_bit_clock) |-> $past(bit_edge);
  endproperty
  a_clk_rise: assert property (p_clk_rise) else $error("bit clock rose off a sample edge"); // [RULE_01]

  property p_bit_period;
    bit_edge && gap_armed && $stable(div_last) |-> gap_cnt == (17'(div_last) + 17'h00001) * 17'h00020 - 17'h00001;
  endproperty
  a_bit_period: assert property (p_bit_period) else $error("bit period differs from divider setting"); // [RULE_02]

  property p_precode;
    s_take3 |=> p1 == $past(line_q ^ p2);
  endproperty
  a_precode: assert property (p_precode) else $error("precoder output wrong"); // [RULE_08]

  property p_encode;
    s_take3 |=> pend_lvl == ($past(p2) ? (p1 ? 3'sd0 : -3'sd1) : (p1 ? 3'sd1 : 3'sd0));
  endproperty
  a_encode: assert property (p_encode) else $error("three level encoder output wrong"); // [RULE_09]

  property p_pair;
    s_take4 |-> $past(bit_edge, 1) == 1'b0 && pair_ph && new_lvl inside {-3'sd3, -3'sd1, 3'sd1, 3'sd3};
  endproperty
  a_pair: assert property (p_pair) else $error("four level symbol off pair boundary"); // [RULE_11]

  property p_latency;
    load && !ovs |-> shp_lvl == pend_lvl ##1 pend_lvl == $past(new_lvl);
  endproperty
  a_latency: assert property (p_latency) else $error("symbol not delayed by one period"); // [RULE_20]

  property p_clear;
    $rose(run) |-> !p1 && !p2 && !pair_ph && pend_lvl == 3'sd0;
  endproperty
  a_clear: assert property (p_clear) else $error("encoder delays not clear at start"); // [RULE_21]

  property p_dev_scale;
    ce && shaped == 8'sh20 |=> freq_dev_cmd == ($past(cfg.halve) ? 17'({$past(cfg.dev), 4'h0}) : 17'({$past(cfg.dev), 5'h00}));
  endproperty
  a_dev_scale: assert property (p_dev_scale) else $error("deviation scaling wrong"); // [RULE_03]

endmodule

// >>> bench/fte_host_model.sv
// host model: shifts a bit pattern onto the data line, timed from the bit clock
module fte_host_model (
  input  logic       clk,
  input  logic       sys_rst,
  input  logic       go,
  input  logic       fill,
  input  logic [9:0] pattern,
  input  logic       host_bit_clock,
  output logic       host_bit_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_d;
  logic       go_d;
  logic [9:0] sh;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_d         <= 1'b0;
      go_d          <= 1'b0;
      sh            <= 10'h000;
      host_bit_line <= 1'b0;
    end else begin
      clk_d <= host_bit_clock;
      go_d  <= go;
      // msb is set up while the clock is still low after a divider write
      if (go && !go_d) begin
        host_bit_line <= pattern[9];
        sh            <= {pattern[8:0], fill};
      end else if (clk_d && !host_bit_clock) begin // change on the falling edge
        host_bit_line <= sh[9];
        sh            <= {sh[8:0], fill};
      end
    end
  end
endmodule

// >>> bench/fte_tx_encoder_tb_top.sv
// testbench of the fsk transmit encoder
module fte_tx_encoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk, sys_rst, ce, go, fill;
  logic [3:0]         s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]        s_axi_wdata, s_axi_rdata;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic               host_bit_line, host_bit_clock, host_bit_clock_oe, sym_strobe;
  logic signed [16:0] freq_dev_cmd;
  logic [9:0]         pattern;
  logic signed [16:0] got[$];
  int                 n_errors, comparisons;
  int                 e3[$] = '{1, 0, -1, 1, 0, 0, 1, 0, 0, -1};
  int                 e4[$] = '{-3, -1, 1, 3};
  logic [31:0]        shp[$] = '{32'h101, 32'h105, 32'h10d, 32'h107, 32'h10f};
  int                 shv[$] = '{-160, 160, -160, 160, -480};
  time                t0;

  fte_tx_encoder DUT (.clk, .ce, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .host_bit_line, .host_bit_clock, .host_bit_clock_oe, .freq_dev_cmd, .sym_strobe);
  fte_host_model host (.clk, .sys_rst, .go, .fill, .pattern, .host_bit_clock, .host_bit_line);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'h0);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'h0);
  endtask

  task automatic edge_w(input logic v);
    do @(posedge clk); while (host_bit_clock !== v);
  endtask

  task automatic send(input logic [9:0] p, input logic f);
    @(posedge clk);
    pattern <= p;
    fill <= f;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  // long enough for the slowest ramp to settle
  task automatic lvl(input logic [31:0] e);
    repeat (400) @(posedge clk);
    chk(32'(freq_dev_cmd), e);
  endtask

  task automatic rec(input int n);
    got.delete();
    repeat (n) begin
      do @(posedge clk); while (sym_strobe !== 1'b1);
      repeat (2) @(posedge clk);
      got.push_back(freq_dev_cmd);
    end
  endtask

  // alignment to the bit clock is not fixed, so look for the run anywhere
  task automatic seek(input int e[$]);
    int hit;
    hit = 0;
    for (int s = 0; s + e.size() <= got.size(); s++) begin
      int m;
      m = 1;
      foreach (e[i]) if (got[s+i] !== 17'(e[i] * 160)) m = 0;
      if (m == 1) hit = 1;
    end
    chk(32'(hit), 32'h1);
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    {sys_rst, ce, s_axi_wstrb} = 6'h3f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go, fill} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pattern} = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h11);
    rd(4'h8, 32'h1);
    wr(4'h8, 32'h1ff);
    rd(4'h8, 32'h1ff);
    wr(4'h8, 32'h5); // deviation an msk host would pick at a quarter rate
    wr(4'h4, 32'h12);
    edge_w(1'b0);
    edge_w(1'b1);
    t0 = $time;
    edge_w(1'b0);
    edge_w(1'b1);
    chk(32'(($time - t0) / 50), 32'h40);
    chk(32'(host_bit_clock_oe), 32'h1);
    wr(4'h4, 32'h11);
    send(10'h3ff, 1'b1);
    wr(4'h0, 32'h100);
    lvl(32'ha0);
    wr(4'h0, 32'h110);
    lvl(32'h50);
    send(10'h000, 1'b0);
    lvl(32'hffffffb0);
    wr(4'h0, 32'h104); // line held without clock, as an asynchronous host would
    lvl(32'hffffff60);
    chk({30'h0, host_bit_clock_oe, host_bit_clock}, 32'h0);
    wr(4'h0, 32'h0);
    wr(4'h0, 32'h102);
    wr(4'h4, 32'h11);
    send(10'h2c9, 1'b0);
    rec(16);
    seek(e3);
    wr(4'h0, 32'h103);
    wr(4'h4, 32'h11);
    send(10'h078, 1'b0);
    rec(8);
    seek(e4);
    send(10'h3ff, 1'b1);
    // alternate the line so each shaped mode but the 3fsk raised cosine one has to ramp to a new level
    foreach (shp[i]) begin
      send(i[0] ? 10'h3ff : 10'h000, i[0]);
      wr(4'h0, shp[i]);
      lvl(32'(shv[i]));
    end
    wrap_up();
  end
endmodule
